// ==== sim/pbc_gpio_bank0_tb.sv ====
// Self-checking testbench for pin bank 0.
module pbc_gpio_bank0_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------
    // Signals
    // ----------------
    typedef struct {
        bit          is_rd; // Read data note, else output note.
        string       nm;    // What is checked.
        logic [31:0] v;     // Expected value.
        logic [31:0] m;     // Bits that count.
    } pbc_note_t;
    logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp, wake, irq;
    logic              usb_reset, lite_reset, reset_protect, nv_load;
    logic [11:0]       haddr;
    logic [1:0]        htrans;
    logic [31:0]       hwdata, hrdata, rd_last;
    logic              rsp_last;
    logic [3:0]        pin_in;
    logic [7:0]        seed;
    pbc_pkg::pbc_src_t nv_src;
    pbc_pkg::pbc_cfg_t nv_image, img;
    pbc_pkg::pbc_pin_t pin;
    pbc_note_t         exp_q[$];
    int                miscompares, n_compared;

    // The only slave's ready is the bus ready.
    pbc_gpio_bank0 dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .usb_reset(usb_reset),
        .lite_reset(lite_reset), .reset_protect(reset_protect), .nv_load(nv_load),
        .nv_src(nv_src), .nv_image(nv_image), .pin_in(pin_in), .pin(pin), .wake(wake),
        .irq(irq));

    initial hclk = 1'b0;
    always #50 hclk = ~hclk;

    // ----------------
    // Tasks
    // ----------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Two generator steps give one 16-bit value.
    task automatic rnd16(output logic [15:0] r);
        seed = lfsr(seed);
        r[7:0] = seed;
        seed = lfsr(seed);
        r[15:8] = seed;
    endtask

    // One single-word transfer; read data is taken at the end of the data phase.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_last = hrdata;
        rsp_last = hresp;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        exp_q.push_back('{1'b1, $sformatf("read %h", a), e, 32'hffffffff});
    endtask

    // Output note: {pin.o, pin.oe, wake, irq} under a mask.
    task automatic chk_out(input string nm, input logic [9:0] v, input logic [9:0] m);
        exp_q.push_back('{1'b0, nm, {22'h0, v}, {22'h0, m}});
    endtask

    // Covers the two synchroniser flops plus the registered event logic.
    task automatic settle();
        repeat (6) @(posedge hclk);
    endtask

    task automatic cmp_rd(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_out(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Monitor: takes the oldest note and compares it with what the block shows.
    initial
    begin
        pbc_note_t n;
        forever
        begin
            wait (exp_q.size() > 0);
            n = exp_q.pop_front();
            if (n.is_rd)
            begin
                cmp_rd(n.nm, n.v, rd_last);
                cmp_rd({n.nm, " response"}, 32'h0, {31'h0, rsp_last});
            end
            else
                cmp_out(n.nm, n.v & n.m, {22'h0, pin.o, pin.oe, wake, irq} & n.m);
        end
    end

    // Watchdog: far beyond the few hundred cycles the tests need.
    initial
    begin
        repeat (6000) @(posedge hclk);
        miscompares++;
        final_report();
    end

    // ----------------
    // Tests
    // ----------------
    initial
    begin
        logic [15:0]       r;
        logic [3:0]        oe;
        pbc_pkg::pbc_src_t srcs[3];
        srcs = '{pbc_pkg::SRC_OTP, pbc_pkg::SRC_EEPROM, pbc_pkg::SRC_NONE};
        {hsel, hwrite, usb_reset, lite_reset, reset_protect, nv_load} = '0;
        {haddr, htrans, hwdata, rd_last, nv_image} = '0;
        nv_src = pbc_pkg::SRC_NONE;
        seed = 8'h03;
        pin_in = 4'h3;
        hresetn = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        settle();
        rd(pbc_pkg::CFG_OFF, {16'h0, 12'hf00, pin_in});
        chk_out("pins at reset", 10'h000, 10'h0ff);
        $display("test defaults done");
        // Random layouts, upper half written with ones that must not stick.
        for (int i = 0; i < 8; i++)
        begin
            rnd16(r);
            pin_in <= seed[5:2];
            xfer(1'b1, pbc_pkg::CFG_OFF, {16'hffff, r});
            settle();
            oe = ~r[15:12] & r[7:4] & (r[11:8] | ~r[3:0]);
            rd(pbc_pkg::CFG_OFF, {16'h0, r[15:4], pin_in});
            chk_out("pin drive", {r[3:0], oe, 2'h0}, {oe, 4'hf, 2'h0});
        end
        $display("test drive done");
        // Events: pins 0 and 2 fire high, pins 1 and 3 fire low.
        xfer(1'b1, pbc_pkg::CFG_OFF, 32'h0);
        xfer(1'b1, pbc_pkg::WAKE_OFF, 32'h0005_000f);
        xfer(1'b1, pbc_pkg::IRQ_MASK_OFF, 32'hf);
        pin_in <= 4'h5;
        settle();
        chk_out("event on", 10'h003, 10'h003);
        rd(pbc_pkg::IRQ_STS_OFF, 32'hf);
        pin_in <= 4'ha;
        xfer(1'b1, pbc_pkg::IRQ_STS_OFF, 32'hf);
        settle();
        chk_out("event cleared", 10'h000, 10'h003);
        xfer(1'b1, pbc_pkg::WAKE_OFF, 32'h0005_0000);
        pin_in <= 4'h5;
        settle();
        chk_out("wake disabled", 10'h001, 10'h003);
        xfer(1'b1, pbc_pkg::IRQ_MASK_OFF, 32'h0);
        settle();
        chk_out("irq masked", 10'h000, 10'h001);
        // Not general purpose, then outputs: neither may raise an event.
        for (int j = 0; j < 2; j++)
        begin
            xfer(1'b1, pbc_pkg::CFG_OFF, j == 0 ? 32'hf000 : 32'h00f0);
            xfer(1'b1, pbc_pkg::WAKE_OFF, 32'h0005_000f);
            xfer(1'b1, pbc_pkg::IRQ_STS_OFF, 32'hf);
            settle();
            chk_out("no event", 10'h000, 10'h002);
            rd(pbc_pkg::IRQ_STS_OFF, 32'h0);
        end
        $display("test events done");
        // Image load then bus or lite reset reloads the image.
        for (int k = 0; k < 3; k++)
        begin
            rnd16(r);
            nv_src   <= srcs[k];
            nv_image <= r;
            nv_load  <= 1'b1;
            @(posedge hclk);
            nv_load  <= 1'b0;
            xfer(1'b1, pbc_pkg::CFG_OFF, 32'h0a50);
            img = (k == 2) ? pbc_pkg::CFG_RST : r;
            lite_reset <= k[0];
            usb_reset  <= ~k[0];
            repeat (2) @(posedge hclk);
            {lite_reset, usb_reset} <= 2'h0;
            rd(pbc_pkg::CFG_OFF, {16'h0, img[15:4], pin_in});
        end
        xfer(1'b1, pbc_pkg::CFG_OFF, 32'h05a5);
        {reset_protect, usb_reset, lite_reset} <= 3'h7;
        repeat (2) @(posedge hclk);
        {reset_protect, usb_reset, lite_reset} <= 3'h0;
        rd(pbc_pkg::CFG_OFF, {16'h0, 12'h05a, pin_in});
        xfer(1'b1, 12'h0fc, 32'hffffffff);
        rd(12'h0fc, 32'h0);
        $display("test reload done");
        wait (exp_q.size() == 0);
        final_report();
    end
endmodule

// ==== verilog/pbc_gpio_bank0.sv ====
// Pin bank 0 configuration, data and wake logic with an AHB-Lite register slave.
module pbc_gpio_bank0 #(
    parameter int NPINS = 4 // Pins in this bank.
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [11:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic                usb_reset,
    input  wire logic                lite_reset,
    input  wire logic                reset_protect,
    input  wire logic                nv_load,
    input  wire pbc_pkg::pbc_src_t   nv_src,
    input  wire pbc_pkg::pbc_cfg_t   nv_image,
    input  wire logic [3:0]          pin_in,
    output pbc_pkg::pbc_pin_t        pin,
    output logic                     wake,
    output logic                     irq
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    // Each field is four bits wide, so the bank is fixed at four pins.
    if (NPINS != 4)
    begin : g_chk
        $error("Pin bank serves exactly four pins.");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // All registered state of the block in one word.
    typedef struct packed {
        pbc_pkg::pbc_cfg_t cfg;     // Live configuration.
        pbc_pkg::pbc_cfg_t image;   // Last loaded nonvolatile image.
        logic [3:0]        wk_en;   // Wake enable per pin.
        logic [3:0]        wk_pol;  // Wake polarity per pin.
        logic [3:0]        sync1;   // First synchroniser stage.
        logic [3:0]        lvl_in;  // Sampled pin level.
        logic [3:0]        sts;     // Sticky event status.
        logic [3:0]        mask;    // Event mask.
        logic              dph;     // Write data phase pending.
        logic [11:0]       waddr;   // Latched write address.
        logic [31:0]       rdata;   // Read data.
        logic              wake;    // Registered wake output.
        pbc_pkg::pbc_pin_t pin;     // Registered pin drive.
    } pbc_state_t;

    pbc_state_t st_q;               // Current state.
    pbc_state_t st_d;               // Next state.

    logic       take;               // Address phase accepted.
    logic [3:0] act;                // Per-pin active condition.
    logic [3:0] ev;                 // Per-pin qualified event.
    logic       wk_src_ok;          // Some enabled wake pin is a general-purpose input.

    // Decode a register read into the bus word.
    function automatic logic [31:0] rd_word(input logic [11:0] a, input pbc_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            pbc_pkg::CFG_OFF:
            begin
                // Upper half reads zero, data field shows the pin level.
                w[15:0] = {s.cfg.fsel, s.cfg.drv, s.cfg.dir, s.lvl_in};
            end
            pbc_pkg::WAKE_OFF:
            begin
                w[pbc_pkg::POL_LSB +: 4] = s.wk_pol;
                w[pbc_pkg::WK_LSB +: 4]  = s.wk_en;
            end
            pbc_pkg::IRQ_STS_OFF:  w[3:0] = s.sts;
            pbc_pkg::IRQ_MASK_OFF: w[3:0] = s.mask;
            default:               w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // An address phase is taken only when the bus is ready and the transfer is real.
    assign take = hsel && hready && htrans[1];

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Computes every register's next value from bus, pins and resets.
    always_comb
    begin
        st_d = st_q;

        // Two-flop sampling of the pin levels.
        st_d.sync1  = pin_in;
        st_d.lvl_in = st_q.sync1;

        // Capture a new image; source order is resolved by the loader.
        if (nv_load)
        begin
            if (nv_src == pbc_pkg::SRC_NONE)
            begin
                st_d.image = pbc_pkg::CFG_RST;
            end
            else
            begin
                st_d.image = nv_image;
            end
        end

        // Write data phase.
        if (st_q.dph)
        begin
            case (st_q.waddr)
                pbc_pkg::CFG_OFF:
                begin
                    // Only the low half is writable.
                    st_d.cfg = pbc_pkg::pbc_cfg_t'(hwdata[15:0]);
                end
                pbc_pkg::WAKE_OFF:
                begin
                    st_d.wk_pol = hwdata[pbc_pkg::POL_LSB +: 4];
                    st_d.wk_en  = hwdata[pbc_pkg::WK_LSB +: 4];
                end
                pbc_pkg::IRQ_MASK_OFF: st_d.mask = hwdata[3:0];
                default:
                begin
                    // Unmapped or read-only words ignore writes.
                end
            endcase
        end

        // Bus or lite reset restores the image unless protection holds it.
        // It comes after the write so that a reset during a data phase wins.
        if ((usb_reset || lite_reset) && !reset_protect)
        begin
            st_d.cfg = nv_load ? st_d.image : st_q.image;
        end

        // Address phase bookkeeping.
        // Every taken transfer keeps the address, but only writes open a data phase; reads answer from the address phase itself.
        st_d.dph   = take && hwrite;
        st_d.waddr = take ? haddr : st_q.waddr;
        if (take && !hwrite)
        begin
            st_d.rdata = rd_word(haddr, st_q);
        end

        // Pin drive: open drain only pulls low.
        // Built from the next configuration so that the pins and the fields agree.
        for (int i = 0; i < 4; i++)
        begin
            st_d.pin.o[i]  = st_d.cfg.lvl[i];
            st_d.pin.oe[i] = !st_d.cfg.fsel[i] && st_d.cfg.dir[i]
                             && (st_d.cfg.drv[i] || !st_d.cfg.lvl[i]);
        end

        // Status: clear by writing one, a new event wins.
        if (st_q.dph && st_q.waddr == pbc_pkg::IRQ_STS_OFF)
        begin
            st_d.sts = st_q.sts & ~hwdata[3:0];
        end
        st_d.sts  = st_d.sts | ev;
        st_d.wake = |(ev & st_q.wk_en);
    end

    // Pins qualified as input general-purpose at their active polarity.
    assign act = ~st_q.cfg.fsel & ~st_q.cfg.dir & ~(st_q.lvl_in ^ st_q.wk_pol);
    assign ev  = act;

    // Checker helper: a wake may only follow an enabled general-purpose input pin.
    assign wk_src_ok = |(~st_q.cfg.dir & ~st_q.cfg.fsel & st_q.wk_en);

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Asynchronous reset loads the fixed defaults.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            // Fixed defaults stand until a nonvolatile image arrives.
            st_q      <= '0;
            st_q.cfg  <= pbc_pkg::CFG_RST;
            st_q.image <= pbc_pkg::CFG_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata    = st_q.rdata;
    // The slave never stalls and always answers OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign pin       = st_q.pin;
    assign wake      = st_q.wake;
    assign irq       = |(st_q.sts & st_q.mask);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // A pin may only be driven while it is a general-purpose output.
    property p_drive(int i);
        @(posedge hclk) disable iff (!hresetn)
        st_q.pin.oe[i] |-> (!st_q.cfg.fsel[i] && st_q.cfg.dir[i]);
    endproperty

    a_drive_gp_only: assert property (p_drive(0))
        else $error("Pin driven while not output.");
    a_drive_output: assert property (p_drive(3))
        else $error("Pin 3 driven while not output.");
    a_drive_pin1: assert property (p_drive(1))
        else $error("Pin 1 driven while not output.");
    a_drive_pin2: assert property (p_drive(2))
        else $error("Pin 2 driven while not output.");

    // Pin 0 in open drain never drives a one.
    a_open_drain_hi: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st_q.cfg.drv[0] && st_q.cfg.lvl[0]) |-> !st_q.pin.oe[0])
        else $error("Open drain drove high.");

    // The pin value always follows the stored data field.
    a_out_value: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q.pin.o == st_q.cfg.lvl) else $error("Pin value differs from data.");

    // A read address phase aimed at the configuration word.
    sequence s_cfg_read;
        take && !hwrite && haddr == pbc_pkg::CFG_OFF;
    endsequence

    // The data field of a read shows the sampled pins, not the stored value.
    a_read_level: assert property (@(posedge hclk) disable iff (!hresetn)
        s_cfg_read |=> hrdata[3:0] == $past(st_q.lvl_in)) else $error("Data read not pin level.");

    // The reserved upper half always reads zero.
    a_read_upper: assert property (@(posedge hclk) disable iff (!hresetn)
        s_cfg_read |=> hrdata[31:16] == 16'h0000) else $error("Upper half not zero.");

    // A wake follows only from an enabled general-purpose input pin.
    a_wake_input: assert property (@(posedge hclk) disable iff (!hresetn)
        wake |-> $past(wk_src_ok)) else $error("Bad wake source.");

    // With no wake enable set, no wake follows.
    a_wake_enable: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_q.wk_en == 4'h0) |=> !wake) else $error("Wake without enable.");

    // With all four pins given to other functions, no wake follows.
    a_wake_gp: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_q.cfg.fsel == 4'hf) |=> !wake) else $error("Wake from non general pin.");

    // An unprotected lite reset reloads the last image.
    a_reload_image: assert property (@(posedge hclk) disable iff (!hresetn)
        (lite_reset && !reset_protect && !nv_load) |=> st_q.cfg == $past(st_q.image))
        else $error("Reset did not reload image.");

    // A protected bus reset leaves an untouched configuration alone.
    a_protect_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (usb_reset && reset_protect && !st_q.dph) |=> $stable(st_q.cfg))
        else $error("Protected fields changed.");

    // A load with no nonvolatile source takes the fixed defaults.
    a_fixed_default: assert property (@(posedge hclk) disable iff (!hresetn)
        (nv_load && nv_src == pbc_pkg::SRC_NONE) |=> st_q.image == pbc_pkg::CFG_RST)
        else $error("Fixed default not used.");

    // ------------------------------------------------------------
    // Checks on loading, writing, sampling, protection, events and pin drive
    // ------------------------------------------------------------
    // A bus or lite reset that protection lets through, with no load competing.
    sequence s_open_reset;
        (usb_reset || lite_reset) && !reset_protect && !nv_load;
    endsequence

    // A write data phase to the configuration word with no reload competing.
    sequence s_cfg_write;
        st_q.dph && st_q.waddr == pbc_pkg::CFG_OFF
        && !((usb_reset || lite_reset) && !reset_protect);
    endsequence

    // An image load from a nonvolatile source rather than the fixed default.
    sequence s_image_load;
        nv_load && nv_src != pbc_pkg::SRC_NONE;
    endsequence

    // A configuration write lands whole in the low half of the word.
    a_cfg_write: assert property (@(posedge hclk) disable iff (!hresetn)
        s_cfg_write |=> {16'h0000, st_q.cfg} == ($past(hwdata) & 32'h0000_ffff))
        else $error("Configuration write lost.");

    // An open reset reloads the image whether it came from the bus or the lite path.
    a_reload_open: assert property (@(posedge hclk) disable iff (!hresetn)
        s_open_reset |=> st_q.cfg == $past(st_q.image))
        else $error("Open reset did not reload image.");

    // A load from a nonvolatile source keeps the image exactly as delivered.
    a_image_load: assert property (@(posedge hclk) disable iff (!hresetn)
        s_image_load |=> st_q.image == $past(nv_image))
        else $error("Image not captured.");

    // The sampled level trails the pin by the two sampling flops once reset has settled.
    a_level_lag: assert property (@(posedge hclk) disable iff (!hresetn)
        ($past(hresetn, 2) && $past(hresetn)) |-> st_q.lvl_in == $past(pin_in, 2))
        else $error("Sampled level out of step.");

    // A protected lite reset leaves an untouched configuration alone.
    a_protect_lite: assert property (@(posedge hclk) disable iff (!hresetn)
        (lite_reset && reset_protect && !st_q.dph) |=> $stable(st_q.cfg))
        else $error("Protected fields changed on lite reset.");

    // Every firing pin leaves its sticky status bit set one cycle later.
    a_event_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        (|ev) |=> ((st_q.sts & $past(ev)) == $past(ev)))
        else $error("Event did not set status.");

    // Output pin 1 with a zero data bit is pulled low whatever its driver type.
    a_open_drain_lo: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st_q.cfg.fsel[1] && st_q.cfg.dir[1] && !st_q.cfg.lvl[1]) |-> st_q.pin.oe[1])
        else $error("Pin not pulled low.");

endmodule

// ==== verilog/pbc_pkg.sv ====
// Package with register map, field layout, defaults and carrier types for the pin bank.
package pbc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] CFG_OFF      = 12'h018; // Pin bank configuration word.
    localparam logic [11:0] WAKE_OFF     = 12'h020; // Wake enable and polarity word.
    localparam logic [11:0] IRQ_STS_OFF  = 12'h040; // Sticky event status.
    localparam logic [11:0] IRQ_MASK_OFF = 12'h044; // Event mask.
    localparam logic [11:0] NV_CTRL_OFF  = 12'h048; // Nonvolatile image control.

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FSEL_LSB = 12; // Function select field.
    localparam int DRV_LSB  = 8;  // Output driver type field.
    localparam int DIR_LSB  = 4;  // Direction field.
    localparam int LVL_LSB  = 0;  // Data field.
    localparam int POL_LSB  = 16; // Wake polarity field.
    localparam int WK_LSB   = 0;  // Wake enable field.

    // ------------------------------------------------------------
    // Fixed defaults used when no image exists
    // ------------------------------------------------------------
    localparam logic [3:0] FSEL_RST = 4'hf;
    localparam logic [3:0] DRV_RST  = 4'h0;
    localparam logic [3:0] DIR_RST  = 4'h0;
    localparam logic [3:0] LVL_RST  = 4'h0;

    // One configuration image of the pin bank.
    typedef struct packed {
        logic [3:0] fsel;  // One means pin used by another function.
        logic [3:0] drv;   // One means push/pull, zero open drain.
        logic [3:0] dir;   // One means output.
        logic [3:0] lvl;   // Stored output value.
    } pbc_cfg_t;

    localparam pbc_cfg_t CFG_RST = '{FSEL_RST, DRV_RST, DIR_RST, LVL_RST};

    // Pin signals of the bank.
    typedef struct packed {
        logic [3:0] o;     // Output value.
        logic [3:0] oe;    // Output enable, high while driving.
    } pbc_pin_t;

    // Image source encoding.
    typedef enum logic [1:0] {
        SRC_NONE   = 2'h0,
        SRC_OTP    = 2'h1,
        SRC_EEPROM = 2'h3
    } pbc_src_t;

endpackage
